// [bench/audio_codec_model.sv]
// codec model: master clocks and left justified 16-bit stereo frames
// assumes the port is slave, left justified, 16 bits both ways
`timescale 1ns/100ps
module audio_codec_model (
    input wire logic clock,
    input wire logic run,
    input wire logic [15:0] word,
    input wire logic dout,
    output logic bclk,
    output logic lrclk,
    output logic din,
    output logic [15:0] heard
);
    logic [7:0] cnt_ff = 8'h00;
    logic [15:0] sh_ff = 16'h0000;
    wire logic [7:0] nxt_cnt = cnt_ff + 8'h01;
    initial {bclk, lrclk, din, heard} = 19'h0;
    // half bit clock of 4 cycles leaves the port time to settle dout
    always @(posedge clock) begin
        cnt_ff <= run ? nxt_cnt : 8'h00;
        bclk <= run & nxt_cnt[2];
        lrclk <= run & ~nxt_cnt[7];
        din <= run ? word[4'hF - nxt_cnt[6:3]] : ~din;
        if (run && nxt_cnt[2:0] == 3'h4) begin
            sh_ff <= {sh_ff[14:0], dout};
            if (nxt_cnt[6:3] == 4'hF)
                heard <= {sh_ff[14:0], dout};
        end
    end
endmodule

// [bench/stereo_audio_serial_port_tb.sv]
// self-checking bench for the stereo audio serial port
// assumes the codec model plays the far side in master mode, driving bclk and lrclk
`timescale 1ns/100ps
module stereo_audio_serial_port_tb;
    logic clock = 1'h0, rst = 1'h1, run = 1'h0, mclk_in = 1'h0;
    logic rec_tick = 1'h0, source_present = 1'h0, s_axi_bready = 1'h0;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_rready = 1'h0;
    logic s_axi_arvalid = 1'h0, s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, rd_data, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic [23:0] play_left = 24'h0, play_right = 24'h0, cap_left, cap_right;
    logic [15:0] word = 16'h0, heard;
    logic [1:0] rd_resp, wr_resp, s_axi_bresp, s_axi_rresp;
    logic s_axi_arready, s_axi_rvalid, mclk_out, mclk_oe_n, bclk_out, acc;
    logic bclk_oe_n, lrclk_out, lrclk_oe_n, bclk_in, lrclk_in, din, dout;
    logic play_load, cap_valid, mq, bq;
    int miscompares = 0, check_count = 0, frames = 0, loads = 0;
    int f0, l0, mr = 0, br = 0;
    audio_serial_port u_dut (.clock(clock), .rst(rst),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .mclk_in(mclk_in),
        .mclk_out(mclk_out), .mclk_oe_n(mclk_oe_n), .bclk_in(bclk_in),
        .bclk_out(bclk_out), .bclk_oe_n(bclk_oe_n), .lrclk_in(lrclk_in),
        .lrclk_out(lrclk_out), .lrclk_oe_n(lrclk_oe_n), .din(din),
        .dout(dout), .rec_tick(rec_tick), .source_present(source_present),
        .play_left(play_left), .play_right(play_right),
        .play_load(play_load), .cap_left(cap_left), .cap_right(cap_right),
        .cap_valid(cap_valid));
    audio_codec_model u_codec (.clock(clock), .run(run), .word(word),
        .dout(dout), .bclk(bclk_in), .lrclk(lrclk_in), .din(din),
        .heard(heard));
    initial forever #4 clock = ~clock;
    always @(posedge clock) rec_tick <= ~rec_tick;
    always @(posedge clock) begin
        frames <= frames + int'(cap_valid === 1'h1);
        loads <= loads + int'(play_load === 1'h1);
    end
    initial begin
        #200000;
        miscompares++;
        end_of_test();
    end
    task automatic chk(input string name, input logic [31:0] seen, exp);
        check_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // -------------------------------------------------------------
    // register bus
    // -------------------------------------------------------------
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        do begin
            @(posedge clock);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
        end while (s_axi_bvalid !== 1'h1);
        wr_resp = s_axi_bresp;
    endtask
    task automatic rd(input logic [7:0] a);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do begin
            @(posedge clock);
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
        end while (s_axi_rvalid !== 1'h1);
        rd_data = s_axi_rdata;
        rd_resp = s_axi_rresp;
    endtask
    initial begin
        void'($urandom(48));
        repeat (10) @(posedge clock);
        rst <= 1'h0;
        @(posedge clock);
        chk("oe_n", {mclk_oe_n, bclk_oe_n, lrclk_oe_n}, 32'h7);
        chk("dout", dout, 32'h0);
        rd(8'h1C);
        chk("rx_ctrl", rd_data, 32'h06);
        rd(8'h20);
        chk("pwr_ctrl", rd_data, 32'h20);
        rd(8'h40);
        chk("bad_resp", rd_resp, 32'h2);
        wr(8'h40, 32'hFF);
        chk("bad_wr", wr_resp, 32'h2);
        source_present <= 1'h1;
        wr(8'h20, 32'h00);
        chk("wr_resp", wr_resp, 32'h0);
        wr(8'h1C, 32'h41);
        rd(8'h1C);
        chk("rx_back", rd_data, 32'h41);
        repeat (40) @(posedge clock);
        chk("master_oe", {mclk_oe_n, bclk_oe_n, lrclk_oe_n}, 32'h0);
        // 64 cycles span whole periods of both clocks
        {mq, bq} = {mclk_out, bclk_out};
        repeat (64) begin
            @(posedge clock);
            mr += int'(mclk_out & ~mq);
            br += int'(bclk_out & ~bq);
            {mq, bq} = {mclk_out, bclk_out};
        end
        chk("mclk_rises", mr, 32'h10);
        chk("bclk_rises", br, 32'h4);
        source_present <= 1'h0;
        repeat (40) @(posedge clock);
        acc = 1'h0;
        repeat (16) @(posedge clock) acc = acc | bclk_out | lrclk_out;
        chk("lost_clk", acc, 32'h0);
        $display("test registers and master done");
        wr(8'h1C, 32'h01);
        wr(8'h18, 32'h01);
        run <= 1'h1;
        for (int i = 0; i < 3; i++) begin
            word <= 16'($urandom);
            play_left <= 24'($urandom);
            repeat (2) @(posedge clock);
            play_right <= play_left;
            repeat (900) @(posedge clock);
            chk("cap_left", cap_left, {word, 8'h00});
            chk("cap_right", cap_right, {word, 8'h00});
            chk("heard", heard, play_left[23:8]);
        end
        chk("frames", frames > 4, 32'h1);
        chk("loads", loads > 4, 32'h1);
        wr(8'h20, 32'h20);
        repeat (20) @(posedge clock);
        f0 = frames;
        l0 = loads;
        repeat (600) @(posedge clock);
        chk("pd_frames", frames - f0, 32'h0);
        chk("pd_loads", loads - l0, 32'h0);
        chk("pd_dout", dout, 32'h0);
        $display("test audio done");
        end_of_test();
    end
endmodule

// [hw/audio_serial_pkg.sv]
// constants of the stereo audio serial port
// assumes a single 125 MHz clock and an AXI4-Lite register master
package audio_serial_pkg;
    // ----------------------------------------------------------------
    // register map
    // ----------------------------------------------------------------
    localparam logic [7:0] TX_CTRL_ADDR = 8'h18;
    localparam logic [7:0] RX_CTRL_ADDR = 8'h1C;
    localparam logic [7:0] PWR_CTRL_ADDR = 8'h20;
    localparam logic [7:0] STATUS_ADDR = 8'h24;
    localparam logic [5:0] TX_CTRL_RESET = 6'h06;
    localparam logic [7:0] RX_CTRL_RESET = 8'h06;
    localparam int FMT_LSB = 0;
    localparam int WL_LSB = 2;
    localparam int BCP_BIT = 4;
    localparam int LRP_BIT = 5;
    localparam int MS_BIT = 6;
    localparam int KEEP_BIT = 7;
    localparam int RATIO_BIT = 0;
    localparam int PD_BIT = 5;
    localparam logic PD_RESET = 1'b1;
    // ----------------------------------------------------------------
    // encodings
    // ----------------------------------------------------------------
    localparam logic [1:0] FMT_RJ = 2'h0;
    localparam logic [1:0] FMT_LJ = 2'h1;
    localparam logic [1:0] FMT_I2S = 2'h2;
    localparam logic [1:0] FMT_DSP = 2'h3;
    localparam logic [1:0] WL_16 = 2'h0;
    localparam logic [1:0] WL_20 = 2'h1;
    localparam logic [5:0] BITS_16 = 6'h10;
    localparam logic [5:0] BITS_20 = 6'h14;
    localparam logic [5:0] BITS_24 = 6'h18;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // ----------------------------------------------------------------
    // master clock generation: last tick of a bit clock half, last bit of a frame
    // ----------------------------------------------------------------
    localparam logic [1:0] DIV_DSP = 2'h0;
    localparam logic [1:0] DIV_128FS = 2'h1;
    localparam logic [1:0] DIV_256FS = 2'h3;
    localparam logic [7:0] FRAME_NORMAL = 8'h3F;
    localparam logic [7:0] FRAME_DSP_128FS = 8'h7F;
    localparam logic [7:0] FRAME_DSP_256FS = 8'hFF;
endpackage

// [hw/audio_serial_port.sv]
// stereo audio serial port with AXI4-Lite control
// assumes all pins synchronous to clock; rec_tick marks half periods
// of the recovered master clock
`timescale 1ns/100ps
module audio_serial_port (
    input wire logic clock,
    input wire logic rst,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic mclk_in,
    output logic mclk_out,
    output logic mclk_oe_n,
    input wire logic bclk_in,
    output logic bclk_out,
    output logic bclk_oe_n,
    input wire logic lrclk_in,
    output logic lrclk_out,
    output logic lrclk_oe_n,
    input wire logic din,
    output logic dout,
    input wire logic rec_tick,
    input wire logic source_present,
    input wire logic [23:0] play_left,
    input wire logic [23:0] play_right,
    output logic play_load,
    output logic [23:0] cap_left,
    output logic [23:0] cap_right,
    output logic cap_valid
);
    logic [5:0] tx_ctrl_ff;
    logic [7:0] rx_ctrl_ff;
    logic pd_ff, ratio_ff;
    logic aw_hold_ff, w_hold_ff, awready_ff, wready_ff, bvalid_ff;
    logic arready_ff, rvalid_ff;
    logic [7:0] awaddr_ff;
    logic [31:0] wdata_ff, rdata_ff;
    logic [3:0] wstrb_ff;
    logic [1:0] bresp_ff, rresp_ff;
    logic mclk_ff, bclk_gen_ff, lr_gen_ff, ms_oe_n_ff;
    logic [1:0] div_cnt_ff;
    logic [7:0] gcnt_ff;
    logic bclk_prev_ff, lr_tprev_ff, lr_rprev_ff;
    logic [7:0] tcnt_ff, dcnt_ff, half_len_ff;
    logic [23:0] sh_ff, cap_left_ff, cap_right_ff, out_l_ff, out_r_ff;
    logic cap_valid_ff, play_load_ff, dout_ff;

    // ----------------------------------------------------------------
    // control fields
    // ----------------------------------------------------------------
    logic ms, keep, tx_dsp, rx_dsp, run;
    logic [5:0] tx_wl, rx_wl;
    logic [1:0] tx_fmt, rx_fmt, div_lim;
    logic [7:0] frame_last;
    assign ms = rx_ctrl_ff[audio_serial_pkg::MS_BIT];
    assign keep = rx_ctrl_ff[audio_serial_pkg::KEEP_BIT];
    assign tx_fmt = tx_ctrl_ff[audio_serial_pkg::FMT_LSB +: 2];
    assign rx_fmt = rx_ctrl_ff[audio_serial_pkg::FMT_LSB +: 2];
    assign tx_dsp = tx_fmt == audio_serial_pkg::FMT_DSP;
    assign rx_dsp = rx_fmt == audio_serial_pkg::FMT_DSP;

    function automatic logic [5:0] wl_bits(input logic [1:0] code);
        case (code)
            audio_serial_pkg::WL_16: wl_bits = audio_serial_pkg::BITS_16;
            audio_serial_pkg::WL_20: wl_bits = audio_serial_pkg::BITS_20;
            default: wl_bits = audio_serial_pkg::BITS_24;
        endcase
    endfunction
    assign tx_wl = wl_bits(tx_ctrl_ff[audio_serial_pkg::WL_LSB +: 2]);
    assign rx_wl = wl_bits(rx_ctrl_ff[audio_serial_pkg::WL_LSB +: 2]);

    // ----------------------------------------------------------------
    // register bus
    // ----------------------------------------------------------------
    logic aw_take, w_take, commit, ar_take, bvalid_nxt, rvalid_nxt;
    assign aw_take = s_axi_awvalid & awready_ff;
    assign w_take = s_axi_wvalid & wready_ff;
    assign commit = aw_hold_ff & w_hold_ff & ~bvalid_ff;
    assign bvalid_nxt = commit | (bvalid_ff & ~s_axi_bready);
    assign ar_take = s_axi_arvalid & arready_ff;
    assign rvalid_nxt = ar_take | (rvalid_ff & ~s_axi_rready);

    always_ff @(posedge clock) begin
        if (rst) begin
            aw_hold_ff <= 1'b0;
            w_hold_ff <= 1'b0;
            awready_ff <= 1'b0;
            wready_ff <= 1'b0;
            bvalid_ff <= 1'b0;
            bresp_ff <= audio_serial_pkg::RESP_OKAY;
            awaddr_ff <= 8'h00;
            wdata_ff <= 32'h00000000;
            wstrb_ff <= 4'h0;
        end else begin
            // address and data may arrive in either order
            if (aw_take) begin
                aw_hold_ff <= 1'b1;
                awaddr_ff <= s_axi_awaddr;
            end else if (commit) begin
                aw_hold_ff <= 1'b0;
            end
            if (w_take) begin
                w_hold_ff <= 1'b1;
                wdata_ff <= s_axi_wdata;
                wstrb_ff <= s_axi_wstrb;
            end else if (commit) begin
                w_hold_ff <= 1'b0;
            end
            awready_ff <= ~aw_take & ~(aw_hold_ff & ~commit) & ~bvalid_nxt;
            wready_ff <= ~w_take & ~(w_hold_ff & ~commit) & ~bvalid_nxt;
            bvalid_ff <= bvalid_nxt;
            if (commit) begin
                case (awaddr_ff)
                    audio_serial_pkg::TX_CTRL_ADDR,
                    audio_serial_pkg::RX_CTRL_ADDR,
                    audio_serial_pkg::PWR_CTRL_ADDR,
                    audio_serial_pkg::STATUS_ADDR: begin
                        bresp_ff <= audio_serial_pkg::RESP_OKAY;
                    end
                    default: bresp_ff <= audio_serial_pkg::RESP_SLVERR;
                endcase
            end
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            tx_ctrl_ff <= audio_serial_pkg::TX_CTRL_RESET;
            rx_ctrl_ff <= audio_serial_pkg::RX_CTRL_RESET;
            pd_ff <= audio_serial_pkg::PD_RESET;
            ratio_ff <= 1'b0;
        end else if (commit && wstrb_ff[0]) begin
            case (awaddr_ff)
                audio_serial_pkg::TX_CTRL_ADDR: tx_ctrl_ff <= wdata_ff[5:0];
                audio_serial_pkg::RX_CTRL_ADDR: rx_ctrl_ff <= wdata_ff[7:0];
                audio_serial_pkg::PWR_CTRL_ADDR: begin
                    pd_ff <= wdata_ff[audio_serial_pkg::PD_BIT];
                    ratio_ff <= wdata_ff[audio_serial_pkg::RATIO_BIT];
                end
                default: ;
            endcase
        end
    end

    // status: source, clocks running, 128fs DSP beyond 16 bits misused
    logic [31:0] rd_mux;
    logic dsp_conflict;
    assign dsp_conflict = ratio_ff & (tx_dsp | rx_dsp)
        & ((tx_dsp & (tx_wl != audio_serial_pkg::BITS_16))
        | (rx_dsp & (rx_wl != audio_serial_pkg::BITS_16)));
    always_comb begin
        case (s_axi_araddr)
            audio_serial_pkg::TX_CTRL_ADDR: rd_mux = {26'h0, tx_ctrl_ff};
            audio_serial_pkg::RX_CTRL_ADDR: rd_mux = {24'h0, rx_ctrl_ff};
            audio_serial_pkg::PWR_CTRL_ADDR:
                rd_mux = {26'h0, pd_ff, 4'h0, ratio_ff};
            audio_serial_pkg::STATUS_ADDR:
                rd_mux = {29'h0, dsp_conflict, run, source_present};
            default: rd_mux = 32'h00000000;
        endcase
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            arready_ff <= 1'b0;
            rvalid_ff <= 1'b0;
            rdata_ff <= 32'h00000000;
            rresp_ff <= audio_serial_pkg::RESP_OKAY;
        end else begin
            arready_ff <= ~ar_take & ~rvalid_nxt;
            rvalid_ff <= rvalid_nxt;
            if (ar_take) begin
                rdata_ff <= rd_mux;
                case (s_axi_araddr)
                    audio_serial_pkg::TX_CTRL_ADDR,
                    audio_serial_pkg::RX_CTRL_ADDR,
                    audio_serial_pkg::PWR_CTRL_ADDR,
                    audio_serial_pkg::STATUS_ADDR: begin
                        rresp_ff <= audio_serial_pkg::RESP_OKAY;
                    end
                    default: rresp_ff <= audio_serial_pkg::RESP_SLVERR;
                endcase
            end
        end
    end

    // ----------------------------------------------------------------
    // master clock generation from the recovered rate
    // ----------------------------------------------------------------
    // mclk_in is not needed: slave timing comes from bclk and lrclk
    assign run = ms & ~pd_ff & (source_present | keep);
    assign div_lim = rx_dsp ? audio_serial_pkg::DIV_DSP
        : (ratio_ff ? audio_serial_pkg::DIV_128FS
        : audio_serial_pkg::DIV_256FS);
    assign frame_last = ~rx_dsp ? audio_serial_pkg::FRAME_NORMAL
        : (ratio_ff ? audio_serial_pkg::FRAME_DSP_128FS
        : audio_serial_pkg::FRAME_DSP_256FS);
    logic [7:0] nxt_gcnt;
    assign nxt_gcnt = (gcnt_ff == frame_last) ? 8'h00 : gcnt_ff + 8'h01;

    always_ff @(posedge clock) begin
        if (rst || !run) begin
            mclk_ff <= 1'b0;
            bclk_gen_ff <= 1'b0;
            lr_gen_ff <= 1'b0;
            div_cnt_ff <= 2'h0;
            gcnt_ff <= 8'h00;
        end else if (rec_tick) begin
            mclk_ff <= ~mclk_ff;
            div_cnt_ff <= (div_cnt_ff == div_lim) ? 2'h0 : div_cnt_ff + 2'h1;
            if (div_cnt_ff == div_lim) begin
                bclk_gen_ff <= ~bclk_gen_ff;
                if (bclk_gen_ff) begin
                    // frame clock moves on the falling bit clock edge
                    gcnt_ff <= nxt_gcnt;
                    lr_gen_ff <= rx_dsp ? (nxt_gcnt == 8'h00) : nxt_gcnt[5];
                end
            end
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            ms_oe_n_ff <= 1'b1;
        end else begin
            ms_oe_n_ff <= ~ms;
        end
    end

    // ----------------------------------------------------------------
    // bit clock edges, per side polarity
    // ----------------------------------------------------------------
    logic bclk_now, lr_now, rise_tx, fall_rx, lr_t, lr_r;
    assign bclk_now = ms ? bclk_gen_ff : bclk_in;
    assign lr_now = ms ? lr_gen_ff : lrclk_in;
    assign rise_tx = (bclk_now ^ tx_ctrl_ff[audio_serial_pkg::BCP_BIT])
        & ~(bclk_prev_ff ^ tx_ctrl_ff[audio_serial_pkg::BCP_BIT]);
    assign fall_rx = ~(bclk_now ^ rx_ctrl_ff[audio_serial_pkg::BCP_BIT])
        & (bclk_prev_ff ^ rx_ctrl_ff[audio_serial_pkg::BCP_BIT]);
    assign lr_t = lr_now ^ (tx_ctrl_ff[audio_serial_pkg::LRP_BIT] & ~tx_dsp);
    assign lr_r = lr_now ^ (rx_ctrl_ff[audio_serial_pkg::LRP_BIT] & ~rx_dsp);

    always_ff @(posedge clock) begin
        if (rst) begin
            bclk_prev_ff <= 1'b0;
        end else begin
            bclk_prev_ff <= bclk_now;
        end
    end

    // ----------------------------------------------------------------
    // input capture on rising edges
    // ----------------------------------------------------------------
    logic t_trans, t_off, t_left;
    logic [7:0] t_cur, t_pos;
    logic [23:0] t_word;
    logic [4:0] t_shift;
    assign t_trans = tx_dsp ? (lr_t & ~lr_tprev_ff) : (lr_t != lr_tprev_ff);
    assign t_cur = t_trans ? 8'h00 : tcnt_ff;
    assign t_off = (tx_fmt == audio_serial_pkg::FMT_I2S) | (tx_dsp
        & ~tx_ctrl_ff[audio_serial_pkg::LRP_BIT]);
    assign t_pos = t_cur - {7'h00, t_off};
    assign t_shift = 5'(audio_serial_pkg::BITS_24 - tx_wl);
    // right-justified words end just before the frame edge
    assign t_word = (tx_fmt == audio_serial_pkg::FMT_RJ) ? sh_ff
        : {sh_ff[22:0], din};
    assign t_left = (tx_fmt == audio_serial_pkg::FMT_I2S) ? ~lr_t : lr_t;

    always_ff @(posedge clock) begin
        if (rst) begin
            lr_tprev_ff <= 1'b0;
            tcnt_ff <= 8'h00;
            sh_ff <= 24'h000000;
            cap_left_ff <= 24'h000000;
            cap_right_ff <= 24'h000000;
            cap_valid_ff <= 1'b0;
        end else begin
            cap_valid_ff <= 1'b0;
            if (rise_tx && !pd_ff) begin
                lr_tprev_ff <= lr_t;
                sh_ff <= {sh_ff[22:0], din};
                tcnt_ff <= (t_cur == 8'hFF) ? t_cur : t_cur + 8'h01;
                if (tx_fmt == audio_serial_pkg::FMT_RJ) begin
                    if (t_trans && lr_tprev_ff) begin
                        cap_left_ff <= t_word << t_shift;
                    end else if (t_trans) begin
                        cap_right_ff <= t_word << t_shift;
                        cap_valid_ff <= 1'b1;
                    end
                end else if (tx_dsp) begin
                    if (t_pos == {2'h0, tx_wl} - 8'h01) begin
                        cap_left_ff <= t_word << t_shift;
                    end else if (t_pos == {1'b0, tx_wl, 1'b0} - 8'h01) begin
                        cap_right_ff <= t_word << t_shift;
                        cap_valid_ff <= 1'b1;
                    end
                end else if (t_pos == {2'h0, tx_wl} - 8'h01) begin
                    if (t_left) begin
                        cap_left_ff <= t_word << t_shift;
                    end else begin
                        cap_right_ff <= t_word << t_shift;
                        cap_valid_ff <= 1'b1;
                    end
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // output shifting on falling edges
    // ----------------------------------------------------------------
    logic r_trans, r_left, r_bit, r_load;
    logic [7:0] r_cur, r_pos, r_k;
    assign r_trans = rx_dsp ? (lr_r & ~lr_rprev_ff) : (lr_r != lr_rprev_ff);
    assign r_cur = r_trans ? 8'h00 : dcnt_ff;
    assign r_left = (rx_fmt == audio_serial_pkg::FMT_I2S) ? ~lr_r : lr_r;
    assign r_load = r_trans & (rx_dsp | r_left);
    always_comb begin
        case (rx_fmt)
            audio_serial_pkg::FMT_RJ:
                r_pos = r_cur - (half_len_ff - {2'h0, rx_wl});
            audio_serial_pkg::FMT_LJ: r_pos = r_cur;
            audio_serial_pkg::FMT_I2S: r_pos = r_cur - 8'h01;
            default: r_pos = rx_ctrl_ff[audio_serial_pkg::LRP_BIT]
                ? r_cur : r_cur - 8'h01;
        endcase
        r_k = r_pos;
        r_bit = 1'b0;
        if (rx_dsp && r_pos >= {2'h0, rx_wl}) begin
            r_k = r_pos - {2'h0, rx_wl};
            if (r_k < {2'h0, rx_wl}) begin
                r_bit = out_r_ff[5'd23 - r_k[4:0]];
            end
        end else if (r_pos < {2'h0, rx_wl}) begin
            // MSB first
            r_bit = (rx_dsp || r_left) ? out_l_ff[5'd23 - r_pos[4:0]]
                : out_r_ff[5'd23 - r_pos[4:0]];
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            lr_rprev_ff <= 1'b0;
            dcnt_ff <= 8'h00;
            half_len_ff <= 8'h00;
            out_l_ff <= 24'h000000;
            out_r_ff <= 24'h000000;
            play_load_ff <= 1'b0;
            dout_ff <= 1'b0;
        end else begin
            play_load_ff <= 1'b0;
            if (pd_ff) begin
                dout_ff <= 1'b0;
            end else if (fall_rx) begin
                lr_rprev_ff <= lr_r;
                dcnt_ff <= (r_cur == 8'hFF) ? r_cur : r_cur + 8'h01;
                if (r_trans) begin
                    half_len_ff <= dcnt_ff;
                end
                if (r_load) begin
                    out_l_ff <= play_left;
                    out_r_ff <= play_right;
                    play_load_ff <= 1'b1;
                end
                // fresh samples must show at the load edge itself
                dout_ff <= r_load ? (r_pos == 8'h00 && play_left[23]) : r_bit;
            end
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign s_axi_awready = awready_ff;
    assign s_axi_wready = wready_ff;
    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp = bresp_ff;
    assign s_axi_arready = arready_ff;
    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rdata = rdata_ff;
    assign s_axi_rresp = rresp_ff;
    assign mclk_out = mclk_ff;
    assign bclk_out = bclk_gen_ff;
    assign lrclk_out = lr_gen_ff;
    assign mclk_oe_n = ms_oe_n_ff;
    assign bclk_oe_n = ms_oe_n_ff;
    assign lrclk_oe_n = ms_oe_n_ff;
    assign dout = dout_ff;
    assign play_load = play_load_ff;
    assign cap_left = cap_left_ff;
    assign cap_right = cap_right_ff;
    assign cap_valid = cap_valid_ff;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    AST_SLAVE_AT_RESET: assert property ($fell(rst) |-> ms_oe_n_ff && !ms)
        else $error("port not slave after reset");
    AST_OE_FOLLOWS_MS: assert property (ms ##1 ms |-> !bclk_oe_n)
        else $error("master clocks not driven");
    AST_CLK_STOP: assert property (!run |=> !mclk_ff && !bclk_gen_ff)
        else $error("clocks run without source");
    AST_BCLK_TOGGLE: assert property (run && rec_tick
        && div_cnt_ff == div_lim |=> $changed(bclk_gen_ff) || !run)
        else $error("bit clock divider missed");
    AST_BCLK_HOLD: assert property (run && rec_tick
        && div_cnt_ff != div_lim |=> $stable(bclk_gen_ff) || !run)
        else $error("bit clock moved early");
    AST_LR_HALF: assert property (run && !rx_dsp
        |-> lr_gen_ff == gcnt_ff[5])
        else $error("frame clock half period wrong");
    AST_DOUT_ON_FALL: assert property ($changed(dout_ff) && !$past(pd_ff)
        |-> $past(fall_rx))
        else $error("output changed off falling edge");
    AST_PD_QUIET: assert property (pd_ff ##1 pd_ff
        |-> !dout_ff && !cap_valid_ff)
        else $error("port active while powered down");
    AST_BRESP_HOLD: assert property (bvalid_ff && !s_axi_bready
        |=> bvalid_ff && $stable(bresp_ff))
        else $error("write response dropped");
    COV_CAPTURE: cover property (cap_valid_ff && !tx_dsp);
    COV_DSP_CAPTURE: cover property (cap_valid_ff && tx_dsp);
    COV_MASTER_LOAD: cover property (play_load_ff && ms);
endmodule
